// File: rtl/acs_consts.svh
// constants of the conversion sequencer: offsets, fields, trigger codes and timing
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH
`define ACS_OFF_CTRL 4'h0
`define ACS_OFF_CONFIG 4'h1
`define ACS_OFF_STATUS 4'h2
`define ACS_OFF_RESULT 4'h3
`define ACS_OFF_PREV 4'h4
`define ACS_OFF_ACC 4'h5
`define ACS_OFF_ERROR 4'h6
`define ACS_OFF_SETPT 4'h7
`define ACS_OFF_THRESH 4'h8
`define ACS_OFF_CHAN 4'h9
`define ACS_OFF_RESHI 4'hA
`define ACS_OFF_ERRHI 4'hB
`define ACS_CTRL_ON 0
`define ACS_CTRL_GO 1
`define ACS_CTRL_CONT 2
`define ACS_CTRL_CLKSEL 3
`define ACS_CTRL_PSIS 4
`define ACS_CTRL_DSEN 5
`define ACS_ST_DONE 0
`define ACS_ST_MATH 1
`define ACS_ST_THR 2
`define ACS_ST_BUSY 3
`define ACS_ST_PEND 4
`define ACS_ST_POWERED 5
`define ACS_CFG_TRIG_LSB 0
`define ACS_TRIG_OFF 5'h00
`define ACS_TRIG_CHAN_WR 5'h1F
`define ACS_TRIG_RESHI_RD 5'h1D
`define ACS_TRIG_ERRHI_RD 5'h1C
`define ACS_TRIG_LAST_HW 5'h17
`define ACS_CONV_BITS 10
`define ACS_TCY_NS 80
`define ACS_CLK_NS 20
`define ACS_RC_DELAY_CYC ((`ACS_TCY_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_BIT_CYC 4
`define ACS_MATH_CYC 2
`endif

// File: rtl/acs_pkg.sv
// types of the conversion sequencer
package acs_pkg;
	typedef enum logic [4:0] {
		ACS_IDLE = 5'h01,
		ACS_DELAY = 5'h02,
		ACS_CONVERT = 5'h04,
		ACS_FINISH = 5'h08,
		ACS_MATH = 5'h10
	} acs_state_t;

	typedef struct packed {
		acs_state_t state;
		logic on;
		logic go;
		logic cont;
		logic clksel;
		logic psis;
		logic dsen;
		logic [4:0] trig_sel;
		logic [5:0] chan;
		logic done;
		logic math;
		logic thr;
		logic pend;
		logic powered;
		logic second;
		logic [9:0] result;
		logic [9:0] prev;
		logic [15:0] acc;
		logic [15:0] err;
		logic [9:0] setpt;
		logic [15:0] thresh;
		logic [9:0] shadow;
		logic [3:0] bitn;
		logic [2:0] tick;
		logic [2:0] trig_sync;
		logic trig_level;
		logic avs_wait;
		logic [31:0] rdata;
		logic busy_out;
		logic done_out;
		logic thr_out;
		logic wake;
	} acs_regs_t;
endpackage : acs_pkg

// File: rtl/acs_sequencer.sv
// conversion sequencer of a 10-bit successive-approximation converter
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
`include "acs_consts.svh"
module acs_sequencer (
	input wire logic sys_clk, // system clock, 50 MHz
	input wire logic reset, // asynchronous reset, active high
	input wire logic [3:0] avs_address, // register word index
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall
	input wire logic [23:1] trigger_sources, // hardware trigger sources by code
	input wire logic sleep_mode, // device is in sleep
	input wire logic interrupt_enable, // converter interrupt enable
	input wire logic [9:0] sample_value, // analog comparator result word
	output logic busy, // conversion in progress
	output logic conversion_done_flag, // copy of done flag
	output logic threshold_flag, // copy of threshold flag
	output logic wake_request // wake from sleep, one-cycle pulse
);
	acs_pkg::acs_regs_t r;
	acs_pkg::acs_regs_t next_r;
	logic wr_hit;
	logic rd_hit;
	logic trig_sel_src;
	logic trig_edge;
	logic sw_trig;
	logic rc_clk;
	logic can_run;
	logic [15:0] diff;

	assign wr_hit = avs_write && r.avs_wait;
	assign rd_hit = avs_read && r.avs_wait;
	assign rc_clk = r.clksel;
	// sleep stalls the system-clock converter only
	assign can_run = r.on && r.powered && (!sleep_mode || rc_clk);

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		trig_sel_src = 1'b0;
		if (r.trig_sel != `ACS_TRIG_OFF && r.trig_sel <= `ACS_TRIG_LAST_HW) begin
			trig_sel_src = trigger_sources[r.trig_sel];
		end
	end
	// second and third stages agree high, last level was low
	assign trig_edge = r.trig_sync[2] && r.trig_sync[1] && !r.trig_level;
	always_comb begin
		sw_trig = 1'b0;
		case (r.trig_sel)
			`ACS_TRIG_CHAN_WR: sw_trig = wr_hit && avs_address == `ACS_OFF_CHAN;
			`ACS_TRIG_RESHI_RD: sw_trig = rd_hit && avs_address == `ACS_OFF_RESHI;
			`ACS_TRIG_ERRHI_RD: sw_trig = rd_hit && avs_address == `ACS_OFF_ERRHI;
			default: sw_trig = 1'b0;
		endcase
	end
	assign diff = 16'({6'h00, r.result}) - 16'({6'h00, r.setpt});

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_r = r;
		next_r.trig_sync = {r.trig_sync[1:0], trig_sel_src};
		if (r.trig_sync[2] == r.trig_sync[1]) begin
			next_r.trig_level = r.trig_sync[1];
		end
		next_r.wake = 1'b0;
		// bus slave: one wait cycle, then answer
		next_r.avs_wait = 1'b1;
		if ((avs_read || avs_write) && r.avs_wait) begin
			next_r.avs_wait = 1'b0;
		end
		if (rd_hit) begin
			case (avs_address)
				`ACS_OFF_CTRL: next_r.rdata = {26'h0, r.dsen, r.psis, r.clksel, r.cont, r.go,
					r.on};
				`ACS_OFF_CONFIG: next_r.rdata = {27'h0, r.trig_sel};
				`ACS_OFF_STATUS: next_r.rdata = {26'h0, r.powered, r.pend,
					!r.state[0], r.thr, r.math, r.done};
				`ACS_OFF_RESULT: next_r.rdata = {22'h0, r.result};
				`ACS_OFF_PREV: next_r.rdata = {22'h0, r.prev};
				`ACS_OFF_ACC: next_r.rdata = {16'h0, r.acc};
				`ACS_OFF_ERROR: next_r.rdata = {16'h0, r.err};
				`ACS_OFF_SETPT: next_r.rdata = {22'h0, r.setpt};
				`ACS_OFF_THRESH: next_r.rdata = {16'h0, r.thresh};
				`ACS_OFF_CHAN: next_r.rdata = {26'h0, r.chan};
				`ACS_OFF_RESHI: next_r.rdata = {30'h0, r.result[9:8]};
				`ACS_OFF_ERRHI: next_r.rdata = {24'h0, r.err[15:8]};
				default: next_r.rdata = 32'h0;
			endcase
		end
		if (wr_hit) begin
			case (avs_address)
				`ACS_OFF_CTRL: begin
					next_r.on = avs_writedata[`ACS_CTRL_ON];
					// go only sets while already on
					next_r.go = avs_writedata[`ACS_CTRL_GO] && r.on;
					next_r.cont = avs_writedata[`ACS_CTRL_CONT];
					next_r.clksel = avs_writedata[`ACS_CTRL_CLKSEL];
					next_r.psis = avs_writedata[`ACS_CTRL_PSIS];
					next_r.dsen = avs_writedata[`ACS_CTRL_DSEN];
					if (avs_writedata[`ACS_CTRL_ON] && !r.on) begin
						next_r.powered = 1'b1;
					end
				end
				`ACS_OFF_CONFIG: next_r.trig_sel = avs_writedata[4:0];
				`ACS_OFF_STATUS: begin
					// write one to clear; software clears done, math and thr
					if (avs_writedata[`ACS_ST_DONE]) next_r.done = 1'b0;
					if (avs_writedata[`ACS_ST_MATH]) next_r.math = 1'b0;
					if (avs_writedata[`ACS_ST_THR]) next_r.thr = 1'b0;
				end
				`ACS_OFF_SETPT: next_r.setpt = avs_writedata[9:0];
				`ACS_OFF_THRESH: next_r.thresh = avs_writedata[15:0];
				`ACS_OFF_CHAN: next_r.chan = avs_writedata[5:0];
				default: next_r.chan = r.chan;
			endcase
		end
		if (!next_r.on) begin
			next_r.go = 1'b0;
		end
		// hardware triggers set go; held pending while sleep blocks the run
		if ((trig_edge || sw_trig) && r.on) begin
			if (sleep_mode && !rc_clk) begin
				next_r.pend = 1'b1;
			end else begin
				next_r.go = 1'b1;
				next_r.powered = 1'b1;
			end
		end
		// a trigger held through sleep also restores converter power
		if (r.pend && !sleep_mode && r.on) begin
			next_r.pend = 1'b0;
			next_r.go = 1'b1;
			next_r.powered = 1'b1;
		end
		case (r.state)
			acs_pkg::ACS_IDLE: begin
				if (r.go && can_run) begin
					next_r.tick = 3'h0;
					next_r.state = rc_clk ? acs_pkg::ACS_DELAY : acs_pkg::ACS_CONVERT;
					next_r.bitn = 4'h0;
				end
			end
			acs_pkg::ACS_DELAY: begin
				next_r.tick = r.tick + 3'h1;
				if (r.tick == 3'(`ACS_RC_DELAY_CYC - 1)) begin
					next_r.tick = 3'h0;
					next_r.state = acs_pkg::ACS_CONVERT;
				end
			end
			acs_pkg::ACS_CONVERT: begin
				next_r.tick = r.tick + 3'h1;
				if (r.tick == 3'(`ACS_BIT_CYC - 1)) begin
					next_r.tick = 3'h0;
					next_r.bitn = r.bitn + 4'h1;
					next_r.shadow = sample_value;
					if (r.bitn == 4'(`ACS_CONV_BITS - 1)) begin
						next_r.state = acs_pkg::ACS_FINISH;
					end
				end
			end
			acs_pkg::ACS_FINISH: begin
				if (!r.psis) next_r.prev = r.result;
				next_r.result = r.shadow;
				next_r.acc = r.acc + 16'({6'h00, r.shadow});
				next_r.done = 1'b1;
				next_r.math = 1'b1;
				if (!r.cont) next_r.go = 1'b0;
				next_r.second = r.dsen ? !r.second : 1'b0;
				next_r.tick = 3'h0;
				next_r.state = acs_pkg::ACS_MATH;
				if (sleep_mode) begin
					if (interrupt_enable) next_r.wake = 1'b1;
					else next_r.powered = 1'b0;
				end
			end
			acs_pkg::ACS_MATH: begin
				// math settles after the done flag
				next_r.tick = r.tick + 3'h1;
				if (r.tick == 3'(`ACS_MATH_CYC - 1)) begin
					if (!r.dsen || !r.second) begin
						next_r.err = diff;
						if ($signed(diff) >= $signed(r.thresh)) next_r.thr = 1'b1;
					end
					next_r.state = acs_pkg::ACS_IDLE;
				end
			end
			default: next_r.state = acs_pkg::ACS_IDLE;
		endcase
		// abort: partial word dropped, result untouched
		if (!r.on || ((r.state == acs_pkg::ACS_DELAY || r.state == acs_pkg::ACS_CONVERT)
			&& !next_r.go)) begin
			next_r.state = acs_pkg::ACS_IDLE;
		end
		next_r.busy_out = !next_r.state[0];
		next_r.done_out = next_r.done;
		next_r.thr_out = next_r.thr;
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			r <= '0;
			r.state <= acs_pkg::ACS_IDLE;
			r.avs_wait <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign avs_readdata = r.rdata;
	assign avs_waitrequest = r.avs_wait;
	assign busy = r.busy_out;
	assign conversion_done_flag = r.done_out;
	assign threshold_flag = r.thr_out;
	assign wake_request = r.wake;

	////////////////////////////////////////////////////////////////////////////////
	sequence s_finish;
		r.state == acs_pkg::ACS_FINISH;
	endsequence
	property p_off_idle;
		@(posedge sys_clk) disable iff (reset) !r.on |=> r.state == acs_pkg::ACS_IDLE;
	endproperty
	a_off_idle: assert property (p_off_idle) else $error("conversion runs while off");
	property p_done_set;
		@(posedge sys_clk) disable iff (reset) s_finish |=> r.done && r.math;
	endproperty
	a_done_set: assert property (p_done_set) else $error("done not set on completion");
	property p_go_clear;
		@(posedge sys_clk) disable iff (reset) s_finish and (!r.cont) |=> !r.go;
	endproperty
	a_go_clear: assert property (p_go_clear) else $error("go not cleared");
	property p_prev;
		@(posedge sys_clk) disable iff (reset)
			s_finish and (!r.psis) |=> r.prev == $past(r.result);
	endproperty
	a_prev: assert property (p_prev) else $error("previous result not copied");
	property p_abort;
		@(posedge sys_clk) disable iff (reset)
			r.state == acs_pkg::ACS_CONVERT && !next_r.go |=> $stable(r.result);
	endproperty
	a_abort: assert property (p_abort) else $error("abort altered result");
	property p_math_after;
		@(posedge sys_clk) disable iff (reset)
			s_finish |=> r.state == acs_pkg::ACS_MATH [*2] ##1 r.state == acs_pkg::ACS_IDLE;
	endproperty
	a_math_after: assert property (p_math_after) else $error("math timing wrong");
	property p_pend;
		@(posedge sys_clk) disable iff (reset)
			sleep_mode && !r.clksel && r.state == acs_pkg::ACS_IDLE |=> r.state == acs_pkg::ACS_IDLE;
	endproperty
	a_pend: assert property (p_pend) else $error("converted in sleep without rc");
	property p_rc_delay;
		@(posedge sys_clk) disable iff (reset)
			r.state == acs_pkg::ACS_IDLE && r.go && can_run && rc_clk |=> r.state == acs_pkg::ACS_DELAY;
	endproperty
	a_rc_delay: assert property (p_rc_delay) else $error("rc start delay missing");
	property p_edge_go;
		@(posedge sys_clk) disable iff (reset)
			trig_edge && r.on && !sleep_mode |=> r.go || r.state == acs_pkg::ACS_FINISH;
	endproperty
	a_edge_go: assert property (p_edge_go) else $error("trigger edge did not set go");
	property p_done_sticky;
		@(posedge sys_clk) disable iff (reset)
			r.done && !(wr_hit && avs_address == `ACS_OFF_STATUS) |=> r.done;
	endproperty
	a_done_sticky: assert property (p_done_sticky) else $error("done cleared by hardware");
endmodule : acs_sequencer
`default_nettype wire

// File: test/acs_sequencer_tb_top.sv
// self-checking bench of the conversion sequencer, driven over its register bus
`timescale 1ns/100ps
`default_nettype none
`include "acs_consts.svh"
module acs_sequencer_tb_top;
	logic sys_clk, reset, avs_read, avs_write, sleep_mode, interrupt_enable;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic avs_waitrequest, busy, conversion_done_flag, threshold_flag, wake_request;
	logic [23:1] trigger_sources;
	logic [9:0] sample_value;
	logic [3:0] tad [3];
	int err_count, checks, cyc, wakes, ta, tb;
	acs_sequencer DUT (
		.sys_clk(sys_clk),
		.reset(reset),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.trigger_sources(trigger_sources),
		.sleep_mode(sleep_mode),
		.interrupt_enable(interrupt_enable),
		.sample_value(sample_value),
		.busy(busy),
		.conversion_done_flag(conversion_done_flag),
		.threshold_flag(threshold_flag),
		.wake_request(wake_request)
	);
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (wake_request === 1'b1) wakes <= wakes + 1;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("mismatches %0d comparisons %0d", err_count, checks);
		if (err_count == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", nm, exp, got);
			err_count++;
		end
	endtask : chk
	// one bus cycle: hold the request until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		// look at waitrequest where it is settled, take the answer at the next rising edge
		@(negedge sys_clk);
		while (avs_waitrequest !== 1'b0 && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		@(posedge sys_clk);
		if (n >= 20) err_count++;
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask : bus
	task automatic rdchk(input string nm, input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(nm, exp, rd);
	endtask : rdchk
	// waits for the done flag, then for the sequencer to go idle
	task automatic wait_end;
		int n;
		n = 0;
		while (conversion_done_flag !== 1'b1 && n < 300) begin
			@(posedge sys_clk);
			n++;
		end
		while (busy !== 1'b0 && n < 300) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 300) err_count++;
	endtask : wait_end
	task automatic timed(input logic [31:0] c, output int t);
		int s;
		bus(1'b1, `ACS_OFF_STATUS, 32'h7);
		s = cyc;
		bus(1'b1, `ACS_OFF_CTRL, c);
		while (conversion_done_flag !== 1'b1 && cyc - s < 300) @(posedge sys_clk);
		t = cyc - s;
		wait_end();
	endtask : timed
	task automatic pulse(input int code);
		trigger_sources[code] <= 1'b1;
		repeat (8) @(posedge sys_clk);
		trigger_sources <= '0;
	endtask : pulse
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#(20000 * 20);
		err_count++;
		report_and_stop();
	end
	initial begin
		reset = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		sleep_mode = 1'b0;
		interrupt_enable = 1'b0;
		trigger_sources = '0;
		sample_value = 10'h2A5;
		err_count = 0;
		checks = 0;
		cyc = 0;
		wakes = 0;
		tad = '{`ACS_OFF_CHAN, `ACS_OFF_RESHI, `ACS_OFF_ERRHI};
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		chk("waitrequest", 32'h1, avs_waitrequest);
		rdchk("ctrl", `ACS_OFF_CTRL, 32'h0);
		rdchk("unmapped", 4'hF, 32'h0);
		bus(1'b1, `ACS_OFF_CTRL, 32'h3);
		repeat (10) @(posedge sys_clk);
		chk("busy off", 32'h0, busy);
		rdchk("ctrl go", `ACS_OFF_CTRL, 32'h1);
		timed(32'h3, ta);
		rdchk("result", `ACS_OFF_RESULT, 32'h2A5);
		rdchk("ctrl done", `ACS_OFF_CTRL, 32'h1);
		rdchk("status", `ACS_OFF_STATUS, 32'h27);
		sample_value <= 10'h155;
		bus(1'b1, `ACS_OFF_SETPT, 32'h100);
		bus(1'b1, `ACS_OFF_THRESH, 32'h7FFF);
		timed(32'h3, ta);
		rdchk("prev", `ACS_OFF_PREV, 32'h2A5);
		rdchk("acc", `ACS_OFF_ACC, 32'h3FA);
		rdchk("error", `ACS_OFF_ERROR, 32'h55);
		chk("thr low", 32'h0, threshold_flag);
		bus(1'b1, `ACS_OFF_THRESH, 32'h0);
		timed(32'h3, ta);
		chk("thr high", 32'h1, threshold_flag);
		timed(32'hB, tb);
		chk("rc delay", `ACS_RC_DELAY_CYC, tb - ta);
		// abort in mid-conversion keeps the old result and the done flag
		sample_value <= 10'h0F0;
		bus(1'b1, `ACS_OFF_CTRL, 32'h3);
		repeat (10) @(posedge sys_clk);
		bus(1'b1, `ACS_OFF_CTRL, 32'h1);
		repeat (60) @(posedge sys_clk);
		chk("busy abort", 32'h0, busy);
		rdchk("kept", `ACS_OFF_RESULT, 32'h155);
		chk("done held", 32'h1, conversion_done_flag);
		bus(1'b1, `ACS_OFF_STATUS, 32'h7);
		chk("done clr", 32'h0, conversion_done_flag);
		// continuous mode retriggers and keeps go set
		bus(1'b1, `ACS_OFF_CTRL, 32'h7);
		wait_end();
		bus(1'b1, `ACS_OFF_STATUS, 32'h7);
		wait_end();
		rdchk("cont go", `ACS_OFF_CTRL, 32'h7);
		bus(1'b1, `ACS_OFF_CTRL, 32'h1);
		repeat (60) @(posedge sys_clk);
		trigger_sources <= '1;
		repeat (60) @(posedge sys_clk);
		chk("code zero", 32'h0, busy);
		trigger_sources <= '0;
		for (int c = 1; c <= 23; c++) begin
			bus(1'b1, `ACS_OFF_CONFIG, c);
			bus(1'b1, `ACS_OFF_STATUS, 32'h7);
			pulse(c);
			wait_end();
			repeat (10) @(posedge sys_clk);
			chk("one per edge", 32'h0, busy);
			chk("hw done", 32'h1, conversion_done_flag);
		end
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, `ACS_OFF_CONFIG, 32'h1F - (i == 0 ? 0 : i + 1));
			bus(1'b1, `ACS_OFF_STATUS, 32'h7);
			bus(i == 0, tad[i], 32'h0);
			wait_end();
			chk("bus trig", 32'h1, conversion_done_flag);
		end
		// sleep: rc clock converts and wakes, other clock holds the trigger
		bus(1'b1, `ACS_OFF_CONFIG, 32'h1);
		bus(1'b1, `ACS_OFF_CTRL, 32'h9);
		bus(1'b1, `ACS_OFF_STATUS, 32'h7);
		sleep_mode <= 1'b1;
		interrupt_enable <= 1'b1;
		pulse(1);
		wait_end();
		chk("wake", 32'h1, wakes);
		chk("sleep done", 32'h1, conversion_done_flag);
		interrupt_enable <= 1'b0;
		pulse(1);
		wait_end();
		rdchk("still on", `ACS_OFF_CTRL, 32'h9);
		rdchk("powered", `ACS_OFF_STATUS, 32'h3);
		bus(1'b1, `ACS_OFF_CTRL, 32'h1);
		bus(1'b1, `ACS_OFF_STATUS, 32'h7);
		pulse(1);
		repeat (80) @(posedge sys_clk);
		chk("held", 32'h0, busy);
		rdchk("pending", `ACS_OFF_STATUS, 32'h10);
		sleep_mode <= 1'b0;
		wait_end();
		chk("late done", 32'h1, conversion_done_flag);
		bus(1'b1, `ACS_OFF_CTRL, 32'h3);
		repeat (10) @(posedge sys_clk);
		reset <= 1'b1;
		@(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		chk("reset busy", 32'h0, busy);
		rdchk("reset ctrl", `ACS_OFF_CTRL, 32'h0);
		report_and_stop();
	end
endmodule : acs_sequencer_tb_top
`default_nettype wire
